/* rtl/line_sense_pkg.sv */
// package: address, field layout, reset value and scaling constants of the line sense status register
package line_sense_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] STATUS_ADDR       = 8'h13;    // status register index on the serial port
  localparam logic [7:0] STATUS_RESET      = 8'h00;    // value after reset
  localparam logic [7:0] UNMAPPED_DATA     = 8'h00;    // read data for any other address
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int         CODE_MSB          = 7;        // sense code upper bit
  localparam int         CODE_LSB          = 3;        // sense code lower bit
  localparam int         OVL_BIT           = 2;        // live receive overload
  localparam int         DROP_BIT          = 1;        // supply dropout
  localparam int         PROT_BIT          = 0;        // overload protection engaged
  localparam int         CODE_W            = 5;        // sense code width
  // ----------------------------------------
  // sense code values
  // ----------------------------------------
  localparam logic [4:0] CODE_ZERO         = 5'h00;    // no line / low current
  localparam logic [4:0] CODE_MIN          = 5'h01;    // minimum voltage or normal current
  localparam logic [4:0] CODE_MAX_NORMAL   = 5'h1E;    // maximum normal loop current
  localparam logic [4:0] CODE_ALL_ONES     = 5'h1F;    // max voltage or excessive current
  // ----------------------------------------
  // current scaling (inputs given in whole mA)
  // ----------------------------------------
  localparam int         MA_PER_COUNT      = 3;        // 3 mA per code step
  localparam logic [7:0] OVERLOAD_MA       = 8'h8C;    // 140 mA threshold
  localparam logic [7:0] OVERLOAD_CTR21_MA = 8'h38;    // 56 mA threshold in CTR21 mode
  // ----------------------------------------
  // dropout recovery
  // ----------------------------------------
  localparam int         RECOVER_FRAMES    = 16;       // sample frames before dropout clears
endpackage : line_sense_pkg

/* rtl/frame_counter.sv */
// module: counts sample-rate frame strobes while enabled and flags a reached target
module frame_counter #(
  parameter int TARGET = line_sense_pkg::RECOVER_FRAMES   // frames to count
) (
  input  wire logic core_clk_i,   // core clock
  input  wire logic reset_i,      // async reset, active high
  input  wire logic enable_i,     // count while high, restart when low
  input  wire logic strobe_i,     // one-cycle frame strobe
  output logic      done_o        // high once TARGET strobes were seen
);
  import line_sense_pkg::*;

  localparam int CW = $clog2(TARGET + 1);                  // counter width
  localparam logic [CW-1:0] TGT = CW'(TARGET);             // sized target

  logic [CW-1:0] count_r;   // frames seen since enable rose

  // ----------------------------------------
  // frame count
  // ----------------------------------------
  // saturates at the target so a long recovery never wraps back to zero
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      count_r <= '0;
    end else if (!enable_i) begin
      count_r <= '0;                                        // restart on each new recovery
    end else if (strobe_i && count_r != TGT) begin
      count_r <= count_r + CW'(1);
    end
  end

  assign done_o = (count_r == TGT);
endmodule : frame_counter

/* rtl/line_sense_status.sv */
// module: read-only line sense status register with sense code, overload, dropout and protection flags
// What this block does
// - five-bit sense code in bits seven to three
// - on-hook volts 2.75 per count, zero no line
// - on-hook one minimum, all ones maximum
// - off-hook 3 mA per count, capped normal
// - all ones above 140 mA, CTR21 56
// - bit two live receive overload, self clearing
// - overload masked only by settling counter
// - off-hook supply collapse sets dropout bit one
// - dropout clears sixteen frames after recovery
// - on-hook dropout equals line side powered up
// - bit zero shows overload protection engaged
// - ring-zero option forces all ones or zeroes
module line_sense_status #(
  parameter int RECOVER_FRAMES = line_sense_pkg::RECOVER_FRAMES   // dropout recovery frames
) (
  input  wire logic       core_clk_i,               // 10 MHz core clock
  input  wire logic       reset_i,                  // async reset, active high
  // register port
  input  wire logic [7:0] reg_addr_i,               // register index
  input  wire logic       reg_rd_i,                 // read strobe, one cycle
  input  wire logic       reg_wr_i,                 // write strobe, ignored
  output logic      [7:0] reg_rdata_o,              // read data, registered
  // control bits held elsewhere
  input  wire logic       offhook_control_i,        // 1 = off-hook, loop current mode
  input  wire logic       onhook_monitor_select_i,  // on-hook monitor selected
  input  wire logic       ring_zero_option_i,       // ring-zero option
  input  wire logic       billing_tone_enable_i,    // no influence on live overload
  input  wire logic       line_side_powerdown_i,    // line-side device powered down
  input  wire logic       ctr21_mode_i,             // CTR21 termination selected
  // sensed conditions from the line side
  input  wire logic [7:0] line_volt_steps_i,        // line voltage in 2.75 V steps
  input  wire logic       line_present_i,           // a line is connected
  input  wire logic [7:0] loop_ma_i,                // loop current in mA
  input  wire logic       ring_active_i,            // ring event in progress
  input  wire logic       rx_overload_i,            // receive input too large
  input  wire logic       offhook_settling_i,       // off-hook settling counter running
  input  wire logic       line_supply_ok_i,         // line-derived supply up
  input  wire logic       overload_protect_i,       // overload protection engaged
  input  wire logic       sample_strobe_i,          // one pulse per sample frame
  output logic      [7:0] status_o                  // live copy of the status register
);
  import line_sense_pkg::*;

  logic [7:0]        status_r;       // status register
  logic [7:0]        status_nxt;     // its next value
  logic [CODE_W-1:0] code_nxt;       // next sense code
  logic [7:0]        loop_counts;    // loop current in code steps
  logic [7:0]        ovl_thresh;     // active overload threshold
  logic              dropout_r;      // supply dropout flag
  logic              recover_done;   // recovery frames elapsed

  // ----------------------------------------
  // sense code
  // ----------------------------------------
  assign ovl_thresh  = ctr21_mode_i ? OVERLOAD_CTR21_MA : OVERLOAD_MA;
  assign loop_counts = 8'(loop_ma_i / 8'(MA_PER_COUNT));

  // monitor selection; the monitor-select bit only changes the analog path, not the scaling
  always_comb begin
    code_nxt = CODE_ZERO;
    if (ring_zero_option_i && ring_active_i) begin
      code_nxt = line_present_i ? CODE_ALL_ONES : CODE_ZERO;
    end else if (offhook_control_i) begin
      if (loop_ma_i > ovl_thresh) begin
        code_nxt = CODE_ALL_ONES;
      end else if (loop_counts > 8'(CODE_MAX_NORMAL)) begin
        code_nxt = CODE_MAX_NORMAL;
      end else begin
        code_nxt = loop_counts[CODE_W-1:0];
      end
    end else if (!line_present_i) begin
      code_nxt = CODE_ZERO;
    end else if (line_volt_steps_i > 8'(CODE_ALL_ONES)) begin
      code_nxt = CODE_ALL_ONES;
    end else if (line_volt_steps_i < 8'(CODE_MIN)) begin
      code_nxt = CODE_MIN;
    end else begin
      code_nxt = line_volt_steps_i[CODE_W-1:0];
    end
  end

  // ----------------------------------------
  // dropout recovery timer
  // ----------------------------------------
  frame_counter #(
    .TARGET     (RECOVER_FRAMES)
  ) u_recover (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .enable_i   (offhook_control_i && line_supply_ok_i && dropout_r),
    .strobe_i   (sample_strobe_i),
    .done_o     (recover_done)
  );

  // ----------------------------------------
  // dropout flag
  // ----------------------------------------
  // a collapse during recovery wins: the counter restarts from zero
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dropout_r <= 1'b0;
    end else if (!offhook_control_i) begin
      dropout_r <= !line_side_powerdown_i;
    end else if (!line_supply_ok_i) begin
      dropout_r <= 1'b1;
    end else if (recover_done) begin
      dropout_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // status register
  // ----------------------------------------
  always_comb begin
    status_nxt                    = STATUS_RESET;
    status_nxt[CODE_MSB:CODE_LSB] = code_nxt;
    status_nxt[OVL_BIT]           = rx_overload_i && !offhook_settling_i;
    status_nxt[DROP_BIT]          = dropout_r;
    status_nxt[PROT_BIT]          = overload_protect_i;
  end

  // every field tracks its condition; nothing here looks at reads or writes
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      status_r <= STATUS_RESET;
    end else begin
      status_r <= status_nxt;
    end
  end

  assign status_o = status_r;

  // ----------------------------------------
  // register read port
  // ----------------------------------------
  // writes are dropped: the register is read-only and has no side effects
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= UNMAPPED_DATA;
    end else if (reg_rd_i) begin
      reg_rdata_o <= (reg_addr_i == STATUS_ADDR) ? status_r : UNMAPPED_DATA;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  a_ring_ones_shown: assert property (ring_zero_option_i && ring_active_i && line_present_i
    |=> status_r[CODE_MSB:CODE_LSB] == CODE_ALL_ONES) else $error("ring with line not all ones");
  a_ring_zero_shown: assert property (ring_zero_option_i && ring_active_i && !line_present_i
    |=> status_r[CODE_MSB:CODE_LSB] == CODE_ZERO) else $error("ring without line not zero");
  a_no_line_code: assert property (!offhook_control_i && !ring_active_i && !line_present_i
    |=> status_r[CODE_MSB:CODE_LSB] == CODE_ZERO) else $error("no line but code nonzero");
  a_volt_floor_one: assert property (!offhook_control_i && !ring_active_i && line_present_i
    |=> status_r[CODE_MSB:CODE_LSB] >= CODE_MIN) else $error("present line reads zero");
  a_excess_current: assert property (offhook_control_i && !ring_active_i && loop_ma_i > ovl_thresh
    |=> status_r[CODE_MSB:CODE_LSB] == CODE_ALL_ONES) else $error("excess current not flagged");
  a_normal_capped: assert property (offhook_control_i && !ring_active_i && loop_ma_i <= ovl_thresh
    |=> status_r[CODE_MSB:CODE_LSB] <= CODE_MAX_NORMAL) else $error("normal current over cap");
  a_ovl_masked: assert property (offhook_settling_i |=> !status_r[OVL_BIT])
    else $error("overload shown while settling");
  a_ovl_follows: assert property (rx_overload_i && !offhook_settling_i |=> status_r[OVL_BIT])
    else $error("live overload missing");
  a_dropout_sets: assert property (offhook_control_i && !line_supply_ok_i ##1 offhook_control_i
    |=> status_r[DROP_BIT]) else $error("dropout not set");
  a_dropout_holds: assert property (dropout_r && offhook_control_i && line_supply_ok_i && !recover_done
    |=> dropout_r) else $error("dropout cleared early");
  a_onhook_pdown: assert property (!offhook_control_i && line_side_powerdown_i ##1 !offhook_control_i
    |=> !status_r[DROP_BIT]) else $error("dropout set while powered down");
  // the first edge after reset still shows the reset value, whatever the protection input held then
  a_protect_bit: assert property (!$past(reset_i) |-> status_r[PROT_BIT] == $past(overload_protect_i))
    else $error("protect bit mismatch");
  a_read_data: assert property (reg_rd_i && reg_addr_i == STATUS_ADDR |=> reg_rdata_o == $past(status_r))
    else $error("read data wrong");

  c_dropout_recover: cover property (dropout_r ##1 !dropout_r && offhook_control_i);
  c_excess_ctr21:    cover property (offhook_control_i && ctr21_mode_i && loop_ma_i > OVERLOAD_CTR21_MA);
  c_ring_zero:       cover property (ring_zero_option_i && ring_active_i);
  c_status_read:     cover property (reg_rd_i && reg_addr_i == STATUS_ADDR);
endmodule : line_sense_status

/* dv/line_host_model.sv */
// partner: host side of the register port, issuing single-byte reads and writes
module line_host_model (
  input  wire logic       core_clk_i,   // core clock
  input  wire logic [7:0] reg_rdata_i,  // read data from the device
  output logic      [7:0] reg_addr_o,   // register index
  output logic            reg_rd_o,     // read strobe, one cycle
  output logic            reg_wr_o      // write strobe, one cycle
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // idle bus
  // ----------------------------------------
  initial begin
    reg_addr_o = 8'h00;
    reg_rd_o   = 1'b0;
    reg_wr_o   = 1'b0;
  end
  // one transfer: request for one edge, then the index is scrambled so no stale value looks valid
  task access(input logic wr, input logic [7:0] addr, output logic [7:0] data);
    @(posedge core_clk_i);
    reg_addr_o <= addr;
    reg_rd_o   <= !wr;
    reg_wr_o   <= wr;
    @(posedge core_clk_i);
    reg_rd_o   <= 1'b0;
    reg_wr_o   <= 1'b0;
    reg_addr_o <= ~addr;
    @(posedge core_clk_i);
    @(negedge core_clk_i);
    data = reg_rdata_i;
  endtask : access
endmodule : line_host_model

/* dv/line_sense_status_bench.sv */
// bench: drives the line sense status register through its scenarios and reports the verdict
module line_sense_status_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import line_sense_pkg::*;
  localparam int RF = 2;  // short recovery count keeps the run brief
  logic       clk = 1'b0, rst = 1'b1, rd, wr, off = 1'b0, mon = 1'b0, rz = 1'b0, billing_tone_enable = 1'b0, pd = 1'b0;
  logic       ctr = 1'b0, pres = 1'b0, ring = 1'b0, rx = 1'b0, setl = 1'b0, sup = 1'b1, prot = 1'b0, stb = 1'b0;
  logic [7:0] addr, rdata, status, steps = 8'h00, ma = 8'h00, got;
  int         fails = 0, samples_checked = 0, cycles = 0;
  always #50 clk = ~clk;
  line_sense_status #(.RECOVER_FRAMES(RF)) line_sense_status_i (.core_clk_i(clk), .reset_i(rst),
    .reg_addr_i(addr), .reg_rd_i(rd), .reg_wr_i(wr), .reg_rdata_o(rdata), .offhook_control_i(off),
    .onhook_monitor_select_i(mon), .ring_zero_option_i(rz), .billing_tone_enable_i(billing_tone_enable),
    .line_side_powerdown_i(pd), .ctr21_mode_i(ctr), .line_volt_steps_i(steps), .line_present_i(pres),
    .loop_ma_i(ma), .ring_active_i(ring), .rx_overload_i(rx), .offhook_settling_i(setl),
    .line_supply_ok_i(sup), .overload_protect_i(prot), .sample_strobe_i(stb), .status_o(status));
  line_host_model line_host_model_i (.core_clk_i(clk), .reg_rdata_i(rdata), .reg_addr_o(addr),
    .reg_rd_o(rd), .reg_wr_o(wr));
  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // dropout lags inputs by two edges, so wait three before looking
  task settle;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : settle
  task vcase(input logic p, input logic [7:0] s, input logic [4:0] exp);
    @(posedge clk);
    pres  <= p;
    steps <= s;
    settle();
    chk({3'h0, status[7:3]}, {3'h0, exp});
  endtask : vcase
  task icase(input logic c, input logic [7:0] m, input logic [4:0] exp);
    @(posedge clk);
    ctr <= c;
    ma  <= m;
    settle();
    chk({3'h0, status[7:3]}, {3'h0, exp});
  endtask : icase
  task strobe;
    @(posedge clk);
    stb <= 1'b1;
    @(posedge clk);
    stb <= 1'b0;
  endtask : strobe
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_voltage;  // on-hook codes at both ends and past full scale
    vcase(1'b0, 8'h0A, CODE_ZERO);
    vcase(1'b1, 8'h00, CODE_MIN);
    vcase(1'b1, 8'h05, 5'h05);
    vcase(1'b1, 8'h1F, CODE_ALL_ONES);
    vcase(1'b1, 8'h28, CODE_ALL_ONES);
  endtask : t_voltage
  task t_current;  // off-hook codes around both overload thresholds
    @(posedge clk);
    off <= 1'b1;
    icase(1'b0, 8'h02, CODE_ZERO);
    icase(1'b0, 8'h03, CODE_MIN);
    icase(1'b0, 8'h5A, CODE_MAX_NORMAL);
    icase(1'b0, 8'h8C, CODE_MAX_NORMAL);
    icase(1'b0, 8'h8D, CODE_ALL_ONES);
    icase(1'b1, 8'h38, 5'h12);
    icase(1'b1, 8'h39, CODE_ALL_ONES);
    icase(1'b0, 8'h00, CODE_ZERO);
  endtask : t_current
  task t_ring;  // ring event with the option set overrides the voltage code
    @(posedge clk);
    off  <= 1'b0;
    rz   <= 1'b1;
    ring <= 1'b1;
    vcase(1'b1, 8'h05, CODE_ALL_ONES);
    vcase(1'b0, 8'h05, CODE_ZERO);
    @(posedge clk);
    ring <= 1'b0;
  endtask : t_ring
  task t_flags;  // live overload, its mask, protection and on-hook dropout
    @(posedge clk);
    rx  <= 1'b1;
    billing_tone_enable <= 1'b1;
    settle();
    chk({7'h00, status[OVL_BIT]}, 8'h01);
    @(posedge clk);
    setl <= 1'b1;
    settle();
    chk({7'h00, status[OVL_BIT]}, 8'h00);
    @(posedge clk);
    setl <= 1'b0;
    rx   <= 1'b0;
    prot <= 1'b1;
    settle();
    chk(status & 8'h07, 8'h03);
    @(posedge clk);
    pd   <= 1'b1;
    prot <= 1'b0;
    settle();
    chk(status & 8'h07, 8'h00);
  endtask : t_flags
  task t_dropout;  // supply loss while off-hook, then recovery after the frame count
    @(posedge clk);
    off <= 1'b1;
    sup <= 1'b0;
    settle();
    chk({7'h00, status[DROP_BIT]}, 8'h01);
    @(posedge clk);
    sup <= 1'b1;
    repeat (RF - 1) strobe();
    settle();
    chk({7'h00, status[DROP_BIT]}, 8'h01);
    strobe();
    settle();
    chk({7'h00, status[DROP_BIT]}, 8'h00);
  endtask : t_dropout
  task t_register;  // reads and writes leave the flags alone; other indexes read zero
    @(posedge clk);
    off  <= 1'b0;
    prot <= 1'b1;
    vcase(1'b1, 8'h05, 5'h05);
    chk(status, 8'h29);
    line_host_model_i.access(1'b0, STATUS_ADDR, got);
    chk(got, 8'h29);
    line_host_model_i.access(1'b1, STATUS_ADDR, got);
    line_host_model_i.access(1'b0, STATUS_ADDR, got);
    chk(got, 8'h29);
    line_host_model_i.access(1'b0, 8'h12, got);
    chk(got, UNMAPPED_DATA);
  endtask : t_register
  task t_reset;  // mid-run reset with protection engaged, then the register reloads
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(status, STATUS_RESET);
    chk(rdata, STATUS_RESET);
    @(posedge clk);
    rst <= 1'b0;
    settle();
    chk(status, 8'h29);
  endtask : t_reset
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task wrap_up;
    if (fails == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  // hang guard well above the roughly 120 cycles the scenarios need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    chk(status, STATUS_RESET);
    chk(rdata, STATUS_RESET);
    rst <= 1'b0;
    t_voltage();
    t_current();
    t_ring();
    t_flags();
    t_dropout();
    t_register();
    t_reset();
    wrap_up();
  end
endmodule : line_sense_status_bench
